/* include/exec_pkg.sv */
// shared types and constants for the load, multiply, negate and OR execution slice
package exec_pkg;

	// ----------------------------------------
	// condition flag bit positions
	// ----------------------------------------
	localparam int FLAG_Z = 0;
	localparam int FLAG_C = 1;
	localparam int FLAG_V = 2;
	localparam int FLAG_N = 3;
	localparam int FLAG_D = 4;
	localparam int FLAG_U = 5;

	// ----------------------------------------
	// opcode bytes and decode fields
	// ----------------------------------------
	localparam logic [7:0] CODE_LD_SP_BASE = 8'h70;
	localparam logic [7:0] CODE_LD_SP_MASK = 8'hFC;
	localparam logic [7:0] CODE_OR_REG_BASE = 8'h28;
	localparam logic [7:0] CODE_OR_REG_MASK = 8'hFE;
	localparam logic [1:0] PAIR_ACC = 2'h0;
	localparam logic [1:0] PAIR_ADDR = 2'h1;
	localparam logic [1:0] PAIR_IDX1 = 2'h2;
	localparam logic [1:0] PAIR_IDX2 = 2'h3;

	// ----------------------------------------
	// reset values and clock relations
	// ----------------------------------------
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam int CLOCKS_PER_CYCLE = 2;

	// ----------------------------------------
	// clock steps inside an instruction
	// ----------------------------------------
	localparam logic [4:0] STEP_RD0 = 5'h00;
	localparam logic [4:0] STEP_RD1 = 5'h01;
	localparam logic [4:0] STEP_CAP0 = 5'h02;
	localparam logic [4:0] STEP_CAP1 = 5'h03;
	localparam logic [4:0] STEP_WR = 5'h03;

	typedef enum logic [3:0] {
		OP_NOP      = 4'h0,
		OP_OR_REG   = 4'h1,
		OP_OR_IMM   = 4'h2,
		OP_OR_BASE  = 4'h3,
		OP_OR_ABS   = 4'h4,
		OP_LD_SPREL = 4'h5,
		OP_MULTIPLY = 4'h6,
		OP_NEG_REG  = 4'h7,
		OP_NEG_BASE = 4'h8
	} op_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} state_t;

	// instruction cycles and instruction byte lengths
	localparam logic [3:0] CYC_NOP = 4'h2;
	localparam logic [3:0] CYC_OR_REG = 4'h1;
	localparam logic [3:0] CYC_OR_IMM = 4'h2;
	localparam logic [3:0] CYC_OR_BASE = 4'h3;
	localparam logic [3:0] CYC_OR_ABS = 4'h4;
	localparam logic [3:0] CYC_LD_SPREL = 4'h6;
	localparam logic [3:0] CYC_MULTIPLY = 4'hC;
	localparam logic [3:0] CYC_NEG_REG = 4'h3;
	localparam logic [3:0] CYC_NEG_BASE = 4'h5;
	localparam logic [15:0] LEN_ONE = 16'h0001;
	localparam logic [15:0] LEN_TWO = 16'h0002;
	localparam logic [15:0] LEN_THREE = 16'h0003;

	typedef struct packed {
		op_t        op;
		logic [7:0] code;
		logic [7:0] operand;
		logic [7:0] addr_lo;
		logic [7:0] addr_hi;
	} cmd_t;

	typedef struct packed {
		logic [15:0] acc_pair;
		logic [15:0] address_pair;
		logic [15:0] first_index;
		logic [15:0] second_index;
		logic [15:0] stack_pointer;
		logic [15:0] pc;
		logic [7:0]  base_page_register;
		logic [7:0]  data_page_register;
		logic [7:0]  system_condition_flags;
	} regs_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} mem_req_t;

endpackage : exec_pkg

/* logic/exec_slice.sv */
// execution slice: pair load, multiply, negate, no-operation and accumulator OR
//
// What this block does
// - stack-relative pair load: low half from stack pointer plus offset, high from next.
// - displacement is sign-extended, giving offsets -128 to +127.
// - pair field 00 acc, 01 address, 10 first, 11 second index; codes 70H-73H.
// - multiply stores unsigned product of address-pair low byte and accumulator.
// - multiply is refused in configurations 0 and 2.
// - negate base-paged memory byte writes result back, taking 5 cycles.
// - no-operation takes 2 cycles, only advances program counter by one.
// - register OR: accumulator ORed with accumulator (28H) or second byte (29H).
// - immediate OR into accumulator, 2 cycles.
// - base-paged OR: base page high byte, operand low byte, 3 cycles.
// - absolute OR reads 16-bit address from the instruction, 4 cycles.
// - in configurations 2 and 3 data page register supplies upper address bits of base-paged and absolute accesses.
`timescale 1ns/1ps
module exec_slice
(
	input  wire logic              core_clk,
	input  wire logic              arst_n,
	input  wire logic              start,
	input  wire exec_pkg::cmd_t    cmd,
	input  wire logic [1:0]        config_model,
	input  wire logic              ctx_wr,
	input  wire exec_pkg::regs_t   ctx_in,
	input  wire logic [7:0]        mem_rdata,
	output exec_pkg::regs_t        regs_q,
	output exec_pkg::mem_req_t     mem_q,
	output logic                   busy_q,
	output logic                   done_q,
	output logic                   illegal_q
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	exec_pkg::state_t   state_q;
	exec_pkg::state_t   state_d;
	exec_pkg::cmd_t     cur_q;
	exec_pkg::cmd_t     cur_d;
	exec_pkg::regs_t    regs_d;
	exec_pkg::mem_req_t mem_d;
	logic [3:0]         cyc_q;
	logic [3:0]         cyc_d;
	logic               phase_q;
	logic               phase_d;
	logic [3:0]         need_q;
	logic [3:0]         need_d;
	logic [7:0]         d0_q;
	logic [7:0]         d0_d;
	logic [7:0]         d1_q;
	logic [7:0]         d1_d;
	logic               busy_d;
	logic               done_d;
	logic               illegal_d;

	// ----------------------------------------
	// decode and datapath helpers
	// ----------------------------------------
	logic [4:0]  step;
	logic        last;
	logic [7:0]  page;
	logic [23:0] base_addr;
	logic [23:0] abs_addr;
	logic [15:0] sp_addr;
	logic [15:0] product;
	logic [7:0]  neg_in;
	logic [7:0]  neg_out;
	logic [3:0]  neg_flags;
	logic [7:0]  or_src;
	logic [7:0]  or_res;
	logic [3:0]  need;
	logic [15:0] len;
	logic        code_ok;
	logic        mult_ok;

	assign step = {cyc_q, phase_q};
	assign last = phase_q && (cyc_q == 4'(need_q - 4'h1));
	// page bits above the 16-bit address only exist in extended configs
	assign page = config_model[1] ? regs_q.data_page_register : 8'h00;
	assign base_addr = {page, regs_q.base_page_register, cur_q.addr_lo};
	assign abs_addr = {page, cur_q.addr_hi, cur_q.addr_lo};
	assign sp_addr = regs_q.stack_pointer + {{8{cur_q.operand[7]}}, cur_q.operand};
	assign product = regs_q.address_pair[7:0] * regs_q.acc_pair[7:0];
	assign mult_ok = config_model[0];

	always_comb
	begin
		case (cur_q.op)
			exec_pkg::OP_NEG_REG:
				neg_in = cur_q.code[0] ? regs_q.acc_pair[15:8] : regs_q.acc_pair[7:0];
			default:
				neg_in = d0_q;
		endcase
		case (cur_q.op)
			exec_pkg::OP_OR_REG:
				or_src = cur_q.code[0] ? regs_q.acc_pair[15:8] : regs_q.acc_pair[7:0];
			exec_pkg::OP_OR_IMM:
				or_src = cur_q.operand;
			default:
				or_src = d0_q;
		endcase
		or_res = regs_q.acc_pair[7:0] | or_src;
	end

	neg_unit u_neg
	(
		.value    (neg_in),
		.decimal  (regs_q.system_condition_flags[exec_pkg::FLAG_D]),
		.unpacked (regs_q.system_condition_flags[exec_pkg::FLAG_U]),
		.result   (neg_out),
		.nvcz     (neg_flags)
	);

	// cycle count, byte length and code check of an incoming command
	always_comb
	begin
		code_ok = 1'b1;
		case (cmd.op)
			exec_pkg::OP_NOP:
			begin
				need = exec_pkg::CYC_NOP;
				len = exec_pkg::LEN_ONE;
			end
			exec_pkg::OP_OR_REG:
			begin
				need = exec_pkg::CYC_OR_REG;
				len = exec_pkg::LEN_ONE;
				code_ok = (cmd.code & exec_pkg::CODE_OR_REG_MASK) == exec_pkg::CODE_OR_REG_BASE;
			end
			exec_pkg::OP_OR_IMM:
			begin
				need = exec_pkg::CYC_OR_IMM;
				len = exec_pkg::LEN_TWO;
			end
			exec_pkg::OP_OR_BASE:
			begin
				need = exec_pkg::CYC_OR_BASE;
				len = exec_pkg::LEN_TWO;
			end
			exec_pkg::OP_OR_ABS:
			begin
				need = exec_pkg::CYC_OR_ABS;
				len = exec_pkg::LEN_THREE;
			end
			exec_pkg::OP_LD_SPREL:
			begin
				need = exec_pkg::CYC_LD_SPREL;
				len = exec_pkg::LEN_THREE;
				code_ok = (cmd.code & exec_pkg::CODE_LD_SP_MASK) == exec_pkg::CODE_LD_SP_BASE;
			end
			exec_pkg::OP_MULTIPLY:
			begin
				need = exec_pkg::CYC_MULTIPLY;
				len = exec_pkg::LEN_TWO;
				code_ok = mult_ok;
			end
			exec_pkg::OP_NEG_REG:
			begin
				need = exec_pkg::CYC_NEG_REG;
				len = exec_pkg::LEN_TWO;
			end
			exec_pkg::OP_NEG_BASE:
			begin
				need = exec_pkg::CYC_NEG_BASE;
				len = exec_pkg::LEN_THREE;
			end
			default:
			begin
				need = exec_pkg::CYC_NOP;
				len = exec_pkg::LEN_ONE;
				code_ok = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// sequencer and register update
	// ----------------------------------------
	always_comb
	begin
		state_d = state_q;
		cur_d = cur_q;
		regs_d = regs_q;
		cyc_d = cyc_q;
		phase_d = 1'b0;
		need_d = need_q;
		d0_d = d0_q;
		d1_d = d1_q;
		mem_d = '{rd: 1'b0, wr: 1'b0, addr: mem_q.addr, wdata: mem_q.wdata};
		busy_d = busy_q;
		done_d = 1'b0;
		illegal_d = 1'b0;
		case (state_q)
			exec_pkg::ST_IDLE:
			begin
				if (ctx_wr)
					regs_d = ctx_in;
				else if (start && !code_ok)
					illegal_d = 1'b1;
				else if (start)
				begin
					cur_d = cmd;
					need_d = need;
					cyc_d = 4'h0;
					busy_d = 1'b1;
					state_d = exec_pkg::ST_RUN;
					regs_d.pc = regs_q.pc + len;
				end
			end
			exec_pkg::ST_RUN:
			begin
				// phase is the divide-by-two instruction cycle enable
				phase_d = !phase_q;
				if (phase_q)
					cyc_d = 4'(cyc_q + 4'h1);
				case (cur_q.op)
					exec_pkg::OP_OR_BASE, exec_pkg::OP_NEG_BASE:
						if (step == exec_pkg::STEP_RD0)
							mem_d = '{rd: 1'b1, wr: 1'b0, addr: base_addr, wdata: mem_q.wdata};
					exec_pkg::OP_OR_ABS:
						if (step == exec_pkg::STEP_RD0)
							mem_d = '{rd: 1'b1, wr: 1'b0, addr: abs_addr, wdata: mem_q.wdata};
					exec_pkg::OP_LD_SPREL:
						if (step == exec_pkg::STEP_RD0)
							mem_d = '{rd: 1'b1, wr: 1'b0, addr: {8'h00, sp_addr}, wdata: mem_q.wdata};
						else if (step == exec_pkg::STEP_RD1)
							mem_d = '{rd: 1'b1, wr: 1'b0, addr: {8'h00, 16'(sp_addr + 16'h0001)},
								wdata: mem_q.wdata};
					default:
					begin
					end
				endcase
				// read data returns the clock after the strobe is seen
				if (step == exec_pkg::STEP_CAP0)
					d0_d = mem_rdata;
				if (step == exec_pkg::STEP_CAP1)
					d1_d = mem_rdata;
				if (cur_q.op == exec_pkg::OP_NEG_BASE && step == exec_pkg::STEP_WR)
					mem_d = '{rd: 1'b0, wr: 1'b1, addr: base_addr, wdata: neg_out};
				if (last)
				begin
					state_d = exec_pkg::ST_IDLE;
					busy_d = 1'b0;
					done_d = 1'b1;
					case (cur_q.op)
						exec_pkg::OP_OR_REG, exec_pkg::OP_OR_IMM,
						exec_pkg::OP_OR_BASE, exec_pkg::OP_OR_ABS:
						begin
							regs_d.acc_pair[7:0] = or_res;
							regs_d.system_condition_flags[exec_pkg::FLAG_N] = or_res[7];
							regs_d.system_condition_flags[exec_pkg::FLAG_Z] = or_res == 8'h00;
						end
						exec_pkg::OP_LD_SPREL:
							case (cur_q.code[1:0])
								exec_pkg::PAIR_ACC:  regs_d.acc_pair = {d1_q, d0_q};
								exec_pkg::PAIR_ADDR: regs_d.address_pair = {d1_q, d0_q};
								exec_pkg::PAIR_IDX1: regs_d.first_index = {d1_q, d0_q};
								default:             regs_d.second_index = {d1_q, d0_q};
							endcase
						exec_pkg::OP_MULTIPLY:
						begin
							regs_d.address_pair = product;
							regs_d.system_condition_flags[exec_pkg::FLAG_N] = product[15];
							regs_d.system_condition_flags[exec_pkg::FLAG_V] = 1'b0;
							regs_d.system_condition_flags[exec_pkg::FLAG_C] = 1'b0;
							regs_d.system_condition_flags[exec_pkg::FLAG_Z] = product == 16'h0000;
						end
						exec_pkg::OP_NEG_REG, exec_pkg::OP_NEG_BASE:
						begin
							if (cur_q.op == exec_pkg::OP_NEG_REG && cur_q.code[0])
								regs_d.acc_pair[15:8] = neg_out;
							else if (cur_q.op == exec_pkg::OP_NEG_REG)
								regs_d.acc_pair[7:0] = neg_out;
							regs_d.system_condition_flags[exec_pkg::FLAG_N:exec_pkg::FLAG_Z] =
								neg_flags;
						end
						default:
						begin
						end
					endcase
				end
			end
			default:
				state_d = exec_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= exec_pkg::ST_IDLE;
			cur_q <= '{op: exec_pkg::OP_NOP, code: exec_pkg::RST_BYTE, operand: exec_pkg::RST_BYTE,
				addr_lo: exec_pkg::RST_BYTE, addr_hi: exec_pkg::RST_BYTE};
			regs_q <= '{exec_pkg::RST_WORD, exec_pkg::RST_WORD, exec_pkg::RST_WORD,
				exec_pkg::RST_WORD, exec_pkg::RST_WORD, exec_pkg::RST_WORD,
				exec_pkg::RST_BYTE, exec_pkg::RST_BYTE, exec_pkg::RST_FLAGS};
			mem_q <= '{rd: 1'b0, wr: 1'b0, addr: 24'h000000, wdata: exec_pkg::RST_BYTE};
			cyc_q <= 4'h0;
			phase_q <= 1'b0;
			need_q <= 4'h1;
			d0_q <= exec_pkg::RST_BYTE;
			d1_q <= exec_pkg::RST_BYTE;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			illegal_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cur_q <= cur_d;
			regs_q <= regs_d;
			mem_q <= mem_d;
			cyc_q <= cyc_d;
			phase_q <= phase_d;
			need_q <= need_d;
			d0_q <= d0_d;
			d1_q <= d1_d;
			busy_q <= busy_d;
			done_q <= done_d;
			illegal_q <= illegal_d;
		end
	end
endmodule : exec_slice

/* logic/neg_unit.sv */
// byte negate in binary, decimal and unpacked decimal modes, with flags
`timescale 1ns/1ps
module neg_unit
(
	input  wire logic [7:0] value,
	input  wire logic       decimal,
	input  wire logic       unpacked,
	output logic      [7:0] result,
	output logic      [3:0] nvcz
);
	logic [7:0] bin;
	logic [6:0] dig;
	logic [6:0] comp;
	logic [7:0] bcd;

	always_comb
	begin
		bin = 8'(8'h00 - value);
		// widen before the product so the tens digit times ten cannot wrap at four bits
		dig = 7'(value[7:4]) * 7'h0A + 7'(value[3:0]);
		comp = (dig == 7'h00) ? 7'h00 : 7'(7'h64 - dig);
		bcd = {4'(comp / 7'h0A), 4'(comp % 7'h0A)};
		if (unpacked)
			bcd = {4'h0, bcd[3:0]};
		if (decimal)
		begin
			// decimal complement from 100; overflow never arises here
			result = bcd;
			nvcz = {bcd[7], 1'b0, value != 8'h00, bcd == 8'h00};
		end
		else
		begin
			result = bin;
			nvcz = {bin[7], value == 8'h80, value != 8'h00, bin == 8'h00};
		end
	end
endmodule : neg_unit

/* verif/data_mem_model.sv */
// data memory model answering the slice's byte reads and writes
`timescale 1ns/1ps
module data_mem_model
(
	input  wire logic               core_clk,
	input  wire exec_pkg::mem_req_t mem_q,
	output logic [7:0]              mem_rdata
);
	logic [7:0] mem [logic [23:0]];

	// unread cycles show a toggling byte so a late sample cannot pass by luck
	initial mem_rdata = 8'h00;
	always @(posedge core_clk)
	begin
		if (mem_q.wr === 1'b1)
			mem[mem_q.addr] = mem_q.wdata;
		if (mem_q.rd === 1'b1)
			mem_rdata <= mem.exists(mem_q.addr) ? mem[mem_q.addr] : 8'hA5;
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule : data_mem_model

/* verif/exec_slice_monitor.sv */
// concurrent checks on the execution slice ports
`timescale 1ns/1ps
module exec_slice_monitor
(
	input wire logic               core_clk,
	input wire logic               arst_n,
	input wire logic               start,
	input wire exec_pkg::cmd_t     cmd,
	input wire logic [1:0]         config_model,
	input wire logic               ctx_wr,
	input wire exec_pkg::regs_t    regs_q,
	input wire exec_pkg::mem_req_t mem_q,
	input wire logic               busy_q,
	input wire logic               done_q,
	input wire logic               illegal_q
);
	logic take;

	assign take = start && !busy_q && !ctx_wr;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	property p_nop;
		take && cmd.op == exec_pkg::OP_NOP |-> ##5 done_q && regs_q.pc == $past(regs_q.pc, 5)
			+ 16'h0001 && $stable(regs_q.system_condition_flags);
	endproperty
	property p_or_imm;
		take && cmd.op == exec_pkg::OP_OR_IMM |-> ##5 done_q
			&& regs_q.acc_pair[7:0] == ($past(regs_q.acc_pair[7:0], 5) | $past(cmd.operand, 5));
	endproperty
	property p_or_base;
		take && cmd.op == exec_pkg::OP_OR_BASE |-> ##2 mem_q.rd && mem_q.addr
			== {($past(config_model[1], 2) ? $past(regs_q.data_page_register, 2) : 8'h00),
			$past(regs_q.base_page_register, 2), $past(cmd.addr_lo, 2)} ##5 done_q;
	endproperty
	property p_or_abs;
		take && cmd.op == exec_pkg::OP_OR_ABS |-> ##2 mem_q.rd && mem_q.addr
			== {($past(config_model[1], 2) ? $past(regs_q.data_page_register, 2) : 8'h00),
			$past(cmd.addr_hi, 2), $past(cmd.addr_lo, 2)} ##7 done_q;
	endproperty
	property p_ld;
		take && cmd.op == exec_pkg::OP_LD_SPREL
			&& (cmd.code & exec_pkg::CODE_LD_SP_MASK) == exec_pkg::CODE_LD_SP_BASE
			|-> ##2 mem_q.rd && mem_q.addr == {8'h00,
			$past(regs_q.stack_pointer, 2) + {{8{$past(cmd.operand[7], 2)}}, $past(cmd.operand, 2)}}
			##1 mem_q.rd && mem_q.addr == $past(mem_q.addr) + 24'h000001;
	endproperty
	property p_neg_base;
		take && cmd.op == exec_pkg::OP_NEG_BASE |-> ##5 mem_q.wr ##6 done_q;
	endproperty
	property p_mul_bad;
		take && cmd.op == exec_pkg::OP_MULTIPLY && !config_model[0] |-> ##[1:2] illegal_q;
	endproperty
	property p_mul;
		take && cmd.op == exec_pkg::OP_MULTIPLY && config_model[0] |-> ##25 done_q
			&& regs_q.address_pair == {8'h00, $past(regs_q.address_pair[7:0], 25)}
			* {8'h00, $past(regs_q.acc_pair[7:0], 25)};
	endproperty
	property p_mul_flags;
		take && cmd.op == exec_pkg::OP_MULTIPLY && config_model[0] |-> ##25
			regs_q.system_condition_flags[3:0] == {regs_q.address_pair[15], 2'b00,
			regs_q.address_pair == 16'h0000};
	endproperty

	a_nop: assert property (p_nop) else $error("no-operation wrong");
	a_or_imm: assert property (p_or_imm) else $error("immediate OR wrong");
	a_or_base: assert property (p_or_base) else $error("paged OR wrong");
	a_or_abs: assert property (p_or_abs) else $error("absolute OR wrong");
	a_ld: assert property (p_ld) else $error("pair load address wrong");
	a_neg_base: assert property (p_neg_base) else $error("memory negate wrong");
	a_mul_bad: assert property (p_mul_bad) else $error("multiply not refused");
	a_mul: assert property (p_mul) else $error("product wrong");
	a_mul_flags: assert property (p_mul_flags) else $error("product flags wrong");

	c_ld: cover property (take && cmd.op == exec_pkg::OP_LD_SPREL);
	c_illegal: cover property (illegal_q);
	c_write: cover property (mem_q.wr);
endmodule : exec_slice_monitor

/* verif/exec_slice_tb.sv */
// self-checking testbench for the execution slice
`timescale 1ns/1ps
module exec_slice_tb;
	logic               core_clk = 1'b0;
	logic               arst_n = 1'b0;
	logic               start = 1'b0;
	exec_pkg::cmd_t     cmd = '0;
	logic [1:0]         config_model = 2'h0;
	logic               ctx_wr = 1'b0;
	exec_pkg::regs_t    ctx_in = '0;
	logic [7:0]         mem_rdata;
	exec_pkg::regs_t    regs_q;
	exec_pkg::mem_req_t mem_q;
	logic               busy_q;
	logic               done_q;
	logic               illegal_q;
	exec_pkg::regs_t    r;
	logic [15:0]        got;
	int                 n_fail = 0;
	int                 tests_run = 0;

	exec_slice dut (.core_clk(core_clk), .arst_n(arst_n), .start(start), .cmd(cmd),
		.config_model(config_model), .ctx_wr(ctx_wr), .ctx_in(ctx_in), .mem_rdata(mem_rdata),
		.regs_q(regs_q), .mem_q(mem_q), .busy_q(busy_q), .done_q(done_q), .illegal_q(illegal_q));
	data_mem_model mem_i (.core_clk(core_clk), .mem_q(mem_q), .mem_rdata(mem_rdata));

	initial forever #12.5 core_clk = ~core_clk;

	task automatic summarize;
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic load(input exec_pkg::regs_t v);
		ctx_in = v;
		ctx_wr = 1'b1;
		@(posedge core_clk);
		#2 ctx_wr = 1'b0;
	endtask : load

	// n = 0 means the command must be refused
	task automatic run(input exec_pkg::op_t op, input logic [7:0] code, input logic [7:0] opnd,
		input logic [7:0] lo, input logic [7:0] hi, input int n);
		int k;
		k = 0;
		cmd = '{op, code, opnd, lo, hi};
		start = 1'b1;
		@(posedge core_clk);
		#2 start = 1'b0;
		chk(busy_q, n != 0);
		while (done_q !== 1'b1 && illegal_q !== 1'b1 && k < 40)
		begin
			@(posedge core_clk);
			#2 k++;
		end
		if (k >= 40)
		begin
			n_fail++;
			summarize();
		end
		chk(illegal_q, n == 0);
		if (n > 0)
			chk(24'(k), 24'(2 * n));
		chk(busy_q, 1'b0);
		// a refused command returns at once; let an edge pass before the next start
		if (n == 0)
		begin
			@(posedge core_clk);
			#2;
		end
	endtask : run

	task automatic s_bad;
		r = '0;
		r.acc_pair = 16'h0032;
		r.stack_pointer = 16'h1000;
		load(r);
		run(exec_pkg::OP_OR_REG, 8'h2A, 8'h00, 8'h00, 8'h00, 0);
		run(exec_pkg::OP_LD_SPREL, 8'h74, 8'h00, 8'h00, 8'h00, 0);
		run(exec_pkg::op_t'(4'hF), 8'h00, 8'h00, 8'h00, 8'h00, 0);
		chk(regs_q.acc_pair, 16'h0032);
		chk(regs_q.pc, 16'h0000);
	endtask : s_bad

	task automatic s_or;
		r = '0;
		r.acc_pair = 16'h6C32;
		r.system_condition_flags = 8'h06;
		load(r);
		run(exec_pkg::OP_OR_REG, 8'h29, 8'h00, 8'h00, 8'h00, 1);
		chk({regs_q.acc_pair, regs_q.system_condition_flags}, 24'h6C7E06);
		r.acc_pair = 16'h4186;
		load(r);
		run(exec_pkg::OP_OR_REG, 8'h28, 8'h00, 8'h00, 8'h00, 1);
		chk({regs_q.acc_pair, regs_q.system_condition_flags}, 24'h41860E);
		run(exec_pkg::OP_OR_IMM, 8'h00, 8'h41, 8'h00, 8'h00, 2);
		chk(regs_q.acc_pair, 16'h41C7);
	endtask : s_or

	task automatic s_mem_or;
		r = '0;
		r.acc_pair = 16'h0032;
		r.base_page_register = 8'h34;
		r.data_page_register = 8'h12;
		mem_i.mem[24'h123456] = 8'h6C;
		mem_i.mem[24'h003456] = 8'h80;
		mem_i.mem[24'h12ABCD] = 8'h01;
		config_model = 2'h3;
		load(r);
		run(exec_pkg::OP_OR_BASE, 8'h00, 8'h00, 8'h56, 8'h00, 3);
		chk(regs_q.acc_pair, 16'h007E);
		run(exec_pkg::OP_OR_ABS, 8'h00, 8'h00, 8'hCD, 8'hAB, 4);
		chk(regs_q.acc_pair, 16'h007F);
		config_model = 2'h1;
		run(exec_pkg::OP_OR_BASE, 8'h00, 8'h00, 8'h56, 8'h00, 3);
		chk(regs_q.acc_pair, 16'h00FF);
	endtask : s_mem_or

	task automatic s_load;
		r = '0;
		r.stack_pointer = 16'h1000;
		mem_i.mem[24'h000F80] = 8'h64;
		mem_i.mem[24'h000F81] = 8'hE9;
		mem_i.mem[24'h00107F] = 8'h21;
		mem_i.mem[24'h001080] = 8'h35;
		for (int i = 0; i < 4; i++)
		begin
			load(r);
			run(exec_pkg::OP_LD_SPREL, 8'h70 + 8'(i), i[0] ? 8'h7F : 8'h80, 8'h00, 8'h00, 6);
			case (i)
				0: got = regs_q.acc_pair;
				1: got = regs_q.address_pair;
				2: got = regs_q.first_index;
				default: got = regs_q.second_index;
			endcase
			chk(got, i[0] ? 16'h3521 : 16'hE964);
		end
	endtask : s_load

	task automatic s_mul;
		r = '0;
		r.acc_pair = 16'h00A5;
		r.address_pair = 16'h00C8;
		r.system_condition_flags = 8'h07;
		config_model = 2'h1;
		load(r);
		run(exec_pkg::OP_MULTIPLY, 8'h00, 8'h00, 8'h00, 8'h00, 12);
		chk({regs_q.address_pair, regs_q.system_condition_flags}, 24'h80E808);
		r.address_pair = 16'h0000;
		load(r);
		run(exec_pkg::OP_MULTIPLY, 8'h00, 8'h00, 8'h00, 8'h00, 12);
		chk({regs_q.address_pair, regs_q.system_condition_flags}, 24'h000001);
		r.address_pair = 16'h00C8;
		load(r);
		for (int c = 0; c < 4; c += 2)
		begin
			config_model = 2'(c);
			run(exec_pkg::OP_MULTIPLY, 8'h00, 8'h00, 8'h00, 8'h00, 0);
			chk(regs_q.address_pair, 16'h00C8);
		end
	endtask : s_mul

	task automatic s_neg;
		r = '0;
		r.acc_pair = 16'h0080;
		config_model = 2'h0;
		load(r);
		run(exec_pkg::OP_NEG_REG, 8'h00, 8'h00, 8'h00, 8'h00, 3);
		chk({regs_q.acc_pair, regs_q.system_condition_flags}, 24'h00800E);
		r.acc_pair = 16'h0057;
		r.system_condition_flags = 8'h10;
		load(r);
		run(exec_pkg::OP_NEG_REG, 8'h00, 8'h00, 8'h00, 8'h00, 3);
		chk({regs_q.acc_pair, regs_q.system_condition_flags}, 24'h004312);
		r.system_condition_flags = 8'h30;
		load(r);
		run(exec_pkg::OP_NEG_REG, 8'h00, 8'h00, 8'h00, 8'h00, 3);
		chk({regs_q.acc_pair, regs_q.system_condition_flags}, 24'h000332);
		r.acc_pair = 16'h2B00;
		r.system_condition_flags = 8'h00;
		load(r);
		run(exec_pkg::OP_NEG_REG, 8'h01, 8'h00, 8'h00, 8'h00, 3);
		chk({regs_q.acc_pair, regs_q.system_condition_flags}, 24'hD5000A);
		r = '0;
		r.base_page_register = 8'h34;
		mem_i.mem[24'h003456] = 8'h57;
		load(r);
		run(exec_pkg::OP_NEG_BASE, 8'h00, 8'h00, 8'h56, 8'h00, 5);
		chk({mem_i.mem[24'h003456], regs_q.system_condition_flags}, 16'hA90A);
	endtask : s_neg

	task automatic s_nop;
		r = '0;
		r.pc = 16'h1234;
		r.acc_pair = 16'h5A5A;
		r.system_condition_flags = 8'h0F;
		load(r);
		run(exec_pkg::OP_NOP, 8'h00, 8'h00, 8'h00, 8'h00, 2);
		chk(regs_q.pc, 16'h1235);
		chk({regs_q.acc_pair, regs_q.system_condition_flags}, 24'h5A5A0F);
	endtask : s_nop

	initial
	begin
		repeat (4) @(posedge core_clk);
		#2 arst_n = 1'b1;
		s_or();
		s_mem_or();
		s_load();
		s_mul();
		s_neg();
		s_nop();
		s_bad();
		summarize();
	end
endmodule : exec_slice_tb

bind exec_slice exec_slice_monitor mon (.core_clk(core_clk), .arst_n(arst_n), .start(start),
	.cmd(cmd), .config_model(config_model), .ctx_wr(ctx_wr), .regs_q(regs_q), .mem_q(mem_q),
	.busy_q(busy_q), .done_q(done_q), .illegal_q(illegal_q));
